// ===== common/dprp_pkg.sv
// ----------------------------------------------------------------
// Constants and types of the reference profile register bank
// ----------------------------------------------------------------
package dprp_pkg;

   // Bus widths and channel count
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 14;
   localparam int BYTE_W = 8;
   localparam int NCH    = 3;

   // Register indices as printed; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_BW_B0    = 14'h0468;
   localparam logic [IDX_W-1:0] IDX_BW_B1    = 14'h0469;
   localparam logic [IDX_W-1:0] IDX_BW_TOP   = 14'h046A;
   localparam logic [IDX_W-1:0] IDX_DIV_B0   = 14'h046B;
   localparam logic [IDX_W-1:0] IDX_DIV_B1   = 14'h046C;
   localparam logic [IDX_W-1:0] IDX_DIV_TOP  = 14'h046D;
   localparam logic [IDX_W-1:0] IDX_NUM_B0   = 14'h046E;
   localparam logic [IDX_W-1:0] IDX_NUM_B1   = 14'h046F;
   localparam logic [IDX_W-1:0] IDX_NUM_B2   = 14'h0470;
   localparam logic [IDX_W-1:0] IDX_MOD_B0   = 14'h0471;
   localparam logic [IDX_W-1:0] IDX_MOD_B1   = 14'h0472;
   localparam logic [IDX_W-1:0] IDX_MOD_B2   = 14'h0473;
   localparam logic [IDX_W-1:0] IDX_CHAN_CTL = 14'h0400;
   localparam logic [IDX_W-1:0] IDX_APLL_CFG = 14'h0430;

   // Channel mirrors: upper index bits select the channel page
   localparam logic [5:0] PAGE_CH0 = 6'h04;
   localparam logic [5:0] PAGE_CH1 = 6'h05;
   localparam logic [5:0] PAGE_CH2 = 6'h06;

   // Field positions
   localparam int BW_MSB_BIT  = 0;
   localparam int HPM_SEL_BIT = 1;
   localparam int CTL_EN_BIT  = 0;

   // Reset values
   localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
   localparam logic              RST_HPM  = 1'b0;

   // Reference input code of the fourth reference
   localparam logic [1:0] REF_FOURTH = 2'h3;

   // Local register slots inside one channel bank
   typedef enum logic [3:0] {
      SLOT_BW_B0, SLOT_BW_B1, SLOT_BW_TOP,
      SLOT_DIV_B0, SLOT_DIV_B1, SLOT_DIV_TOP,
      SLOT_NUM_B0, SLOT_NUM_B1, SLOT_NUM_B2,
      SLOT_MOD_B0, SLOT_MOD_B1, SLOT_MOD_B2,
      SLOT_CHAN_CTL, SLOT_APLL_CFG
   } dprp_slot_t;

   // Loop profile held for the fourth reference
   typedef struct packed {
      logic [16:0] loop_bw;
      logic        hpm_sel;
      logic [17:0] int_div;
      logic [23:0] frac_num;
      logic [23:0] frac_mod;
   } dprp_profile_t;

   // One byte write into a channel bank
   typedef struct packed {
      logic              en;
      dprp_slot_t        slot;
      logic [BYTE_W-1:0] data;
   } dprp_wr_t;

endpackage

// ===== verilog/dprp_bank.sv
`timescale 1ns/100ps
module dprp_bank (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire dprp_pkg::dprp_wr_t              wr,
   input  wire dprp_pkg::dprp_slot_t            rd_slot,
   output logic [dprp_pkg::BYTE_W-1:0]          rd_data,
   output dprp_pkg::dprp_profile_t              profile_ff,
   output logic [dprp_pkg::BYTE_W-1:0]          chan_ctl_ff,
   output logic [dprp_pkg::BYTE_W-1:0]          apll_cfg_ff
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Byte writes land in their field; reserved bits are never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         profile_ff  <= '0;
         chan_ctl_ff <= dprp_pkg::RST_BYTE;
         apll_cfg_ff <= dprp_pkg::RST_BYTE;
      end else if (wr.en) begin
         case (wr.slot)
            dprp_pkg::SLOT_BW_B0:    profile_ff.loop_bw[7:0]    <= wr.data;
            dprp_pkg::SLOT_BW_B1:    profile_ff.loop_bw[15:8]   <= wr.data;
            dprp_pkg::SLOT_BW_TOP: begin
               profile_ff.loop_bw[16] <= wr.data[dprp_pkg::BW_MSB_BIT];
               profile_ff.hpm_sel     <= wr.data[dprp_pkg::HPM_SEL_BIT];
            end
            dprp_pkg::SLOT_DIV_B0:   profile_ff.int_div[7:0]    <= wr.data;
            dprp_pkg::SLOT_DIV_B1:   profile_ff.int_div[15:8]   <= wr.data;
            dprp_pkg::SLOT_DIV_TOP:  profile_ff.int_div[17:16]  <= wr.data[1:0];
            dprp_pkg::SLOT_NUM_B0:   profile_ff.frac_num[7:0]   <= wr.data;
            dprp_pkg::SLOT_NUM_B1:   profile_ff.frac_num[15:8]  <= wr.data;
            dprp_pkg::SLOT_NUM_B2:   profile_ff.frac_num[23:16] <= wr.data;
            dprp_pkg::SLOT_MOD_B0:   profile_ff.frac_mod[7:0]   <= wr.data;
            dprp_pkg::SLOT_MOD_B1:   profile_ff.frac_mod[15:8]  <= wr.data;
            dprp_pkg::SLOT_MOD_B2:   profile_ff.frac_mod[23:16] <= wr.data;
            dprp_pkg::SLOT_CHAN_CTL: chan_ctl_ff <= wr.data;
            dprp_pkg::SLOT_APLL_CFG: apll_cfg_ff <= wr.data;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read view
   // ----------------------------------------------------------------
   // Reserved upper bits of the top bytes read back as zero
   always_comb begin
      rd_data = dprp_pkg::RST_BYTE;
      case (rd_slot)
         dprp_pkg::SLOT_BW_B0:    rd_data = profile_ff.loop_bw[7:0];
         dprp_pkg::SLOT_BW_B1:    rd_data = profile_ff.loop_bw[15:8];
         dprp_pkg::SLOT_BW_TOP:   rd_data = {6'h00, profile_ff.hpm_sel, profile_ff.loop_bw[16]};
         dprp_pkg::SLOT_DIV_B0:   rd_data = profile_ff.int_div[7:0];
         dprp_pkg::SLOT_DIV_B1:   rd_data = profile_ff.int_div[15:8];
         dprp_pkg::SLOT_DIV_TOP:  rd_data = {6'h00, profile_ff.int_div[17:16]};
         dprp_pkg::SLOT_NUM_B0:   rd_data = profile_ff.frac_num[7:0];
         dprp_pkg::SLOT_NUM_B1:   rd_data = profile_ff.frac_num[15:8];
         dprp_pkg::SLOT_NUM_B2:   rd_data = profile_ff.frac_num[23:16];
         dprp_pkg::SLOT_MOD_B0:   rd_data = profile_ff.frac_mod[7:0];
         dprp_pkg::SLOT_MOD_B1:   rd_data = profile_ff.frac_mod[15:8];
         dprp_pkg::SLOT_MOD_B2:   rd_data = profile_ff.frac_mod[23:16];
         dprp_pkg::SLOT_CHAN_CTL: rd_data = chan_ctl_ff;
         dprp_pkg::SLOT_APLL_CFG: rd_data = apll_cfg_ff;
         default:                 rd_data = dprp_pkg::RST_BYTE;
      endcase
   end

endmodule

// ===== verilog/dprp_apply.sv
`timescale 1ns/100ps
module dprp_apply (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire dprp_pkg::dprp_profile_t profile,
   input  wire logic                    chan_en,
   input  wire logic [1:0]              active_ref,
   output dprp_pkg::dprp_profile_t      applied_ff,
   output logic                         live_ff
);

   logic tracking;

   // Only the fourth reference uses this profile
   assign tracking = chan_en && (active_ref == dprp_pkg::REF_FOURTH);

   // ----------------------------------------------------------------
   // Loop hand-off
   // ----------------------------------------------------------------
   // Applied values freeze when the loop leaves the fourth reference,
   // so a later write cannot disturb a loop locked to another input
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         applied_ff <= '0;
         live_ff    <= 1'b0;
      end else begin
         live_ff <= tracking;
         if (tracking) begin
            applied_ff <= profile;
         end
      end
   end

endmodule

// ===== verilog/dprp_regs.sv
`timescale 1ns/100ps
module dprp_regs (
   input  wire logic                                        pclk,
   input  wire logic                                        presetn,
   input  wire logic                                        psel,
   input  wire logic                                        penable,
   input  wire logic                                        pwrite,
   input  wire logic [dprp_pkg::ADDR_W-1:0]                 paddr,
   input  wire logic [dprp_pkg::DATA_W-1:0]                 pwdata,
   input  wire logic [dprp_pkg::NCH-1:0][1:0]               active_ref,
   output logic [dprp_pkg::DATA_W-1:0]                      prdata,
   output logic                                             pready,
   output logic                                             pslverr,
   output dprp_pkg::dprp_profile_t [dprp_pkg::NCH-1:0]      applied_profile,
   output logic [dprp_pkg::NCH-1:0]                         profile_live,
   output logic [dprp_pkg::NCH-1:0][dprp_pkg::BYTE_W-1:0]   chan_ctl,
   output logic [dprp_pkg::NCH-1:0][dprp_pkg::BYTE_W-1:0]   apll_cfg
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [dprp_pkg::IDX_W-1:0]                  idx;
   logic [dprp_pkg::IDX_W-1:0]                  loc_idx;
   logic [dprp_pkg::NCH-1:0]                    ch_hit;
   logic                                        slot_ok;
   logic                                        prof_slot;
   logic                                        hit;
   dprp_pkg::dprp_slot_t                        slot;
   logic [dprp_pkg::NCH-1:0][dprp_pkg::BYTE_W-1:0] bank_rd;
   logic [dprp_pkg::BYTE_W-1:0]                 sel_rd;
   logic                                        setup;
   logic                                        access_done;
   logic                                        pready_ff;
   logic                                        pslverr_ff;
   logic [dprp_pkg::DATA_W-1:0]                 prdata_ff;
   dprp_pkg::dprp_profile_t [dprp_pkg::NCH-1:0] bank_profile;
   logic [dprp_pkg::NCH-1:0][dprp_pkg::BYTE_W-1:0] ctl_q;
   logic [dprp_pkg::NCH-1:0][dprp_pkg::BYTE_W-1:0] apll_q;

   // Word index; the channel page is folded back onto the first channel
   assign idx     = paddr[dprp_pkg::ADDR_W-1:2];
   assign loc_idx = {dprp_pkg::PAGE_CH0, idx[7:0]};

   // Channel page select
   assign ch_hit[0] = (idx[13:8] == dprp_pkg::PAGE_CH0);
   assign ch_hit[1] = (idx[13:8] == dprp_pkg::PAGE_CH1);
   assign ch_hit[2] = (idx[13:8] == dprp_pkg::PAGE_CH2);

   // Slot lookup inside a page, same layout in every page
   always_comb begin
      slot      = dprp_pkg::SLOT_BW_B0;
      slot_ok   = 1'b1;
      prof_slot = 1'b1;
      case (loc_idx)
         dprp_pkg::IDX_BW_B0:    slot = dprp_pkg::SLOT_BW_B0;
         dprp_pkg::IDX_BW_B1:    slot = dprp_pkg::SLOT_BW_B1;
         dprp_pkg::IDX_BW_TOP:   slot = dprp_pkg::SLOT_BW_TOP;
         dprp_pkg::IDX_DIV_B0:   slot = dprp_pkg::SLOT_DIV_B0;
         dprp_pkg::IDX_DIV_B1:   slot = dprp_pkg::SLOT_DIV_B1;
         dprp_pkg::IDX_DIV_TOP:  slot = dprp_pkg::SLOT_DIV_TOP;
         dprp_pkg::IDX_NUM_B0:   slot = dprp_pkg::SLOT_NUM_B0;
         dprp_pkg::IDX_NUM_B1:   slot = dprp_pkg::SLOT_NUM_B1;
         dprp_pkg::IDX_NUM_B2:   slot = dprp_pkg::SLOT_NUM_B2;
         dprp_pkg::IDX_MOD_B0:   slot = dprp_pkg::SLOT_MOD_B0;
         dprp_pkg::IDX_MOD_B1:   slot = dprp_pkg::SLOT_MOD_B1;
         dprp_pkg::IDX_MOD_B2:   slot = dprp_pkg::SLOT_MOD_B2;
         dprp_pkg::IDX_CHAN_CTL: begin
            slot      = dprp_pkg::SLOT_CHAN_CTL;
            prof_slot = 1'b0;
         end
         dprp_pkg::IDX_APLL_CFG: begin
            slot      = dprp_pkg::SLOT_APLL_CFG;
            prof_slot = 1'b0;
         end
         default: begin
            slot_ok   = 1'b0;
            prof_slot = 1'b0;
         end
      endcase
   end

   // Third channel exposes control and analog loop words only; a
   // misaligned byte address is refused rather than aliased
   assign hit = slot_ok && (paddr[1:0] == 2'h0)
                && (ch_hit[0] || ch_hit[1] || (ch_hit[2] && !prof_slot));

   // Read data of the addressed page
   always_comb begin
      sel_rd = dprp_pkg::RST_BYTE;
      if (ch_hit[1]) begin
         sel_rd = bank_rd[1];
      end else if (ch_hit[2]) begin
         sel_rd = bank_rd[2];
      end else begin
         sel_rd = bank_rd[0];
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // No wait state; read data still comes from a flop at the answer
   assign setup       = psel && !penable;
   assign access_done = psel && penable && pready_ff;

   // Ready pulses in the single access cycle of every transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
      end
   end

   // Error and read data are settled during setup and held for access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end else if (setup) begin
         pslverr_ff <= !hit;
         prdata_ff  <= (hit && !pwrite) ? {24'h000000, sel_rd} : '0;
      end else if (access_done) begin
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ----------------------------------------------------------------
   // Channel banks
   // ----------------------------------------------------------------
   // Every channel has the same bank so reset values match by build;
   // the third bank's profile slots simply never see a write
   for (genvar c = 0; c < dprp_pkg::NCH; c++) begin : g_ch
      dprp_pkg::dprp_wr_t wr_c;

      // Write strobe at the access edge only, never on a refused access;
      // one driver for the whole struct keeps the member writes legal
      assign wr_c = {access_done && pwrite && hit && ch_hit[c],
                     slot,
                     pwdata[dprp_pkg::BYTE_W-1:0]};

      dprp_bank u_bank (
         .pclk        (pclk),
         .presetn     (presetn),
         .wr          (wr_c),
         .rd_slot     (slot),
         .rd_data     (bank_rd[c]),
         .profile_ff  (bank_profile[c]),
         .chan_ctl_ff (ctl_q[c]),
         .apll_cfg_ff (apll_q[c])
      );

      // Control enable bit gates the hand-off to the loop
      dprp_apply u_apply (
         .pclk       (pclk),
         .presetn    (presetn),
         .profile    (bank_profile[c]),
         .chan_en    (ctl_q[c][dprp_pkg::CTL_EN_BIT]),
         .active_ref (active_ref[c]),
         .applied_ff (applied_profile[c]),
         .live_ff    (profile_live[c])
      );

      assign chan_ctl[c] = ctl_q[c];
      assign apll_cfg[c] = apll_q[c];
   end

endmodule

// ===== tb/dprp_regs_props.sv
`timescale 1ns/100ps
// ----------------------------------------------
// Bus timing, decode and loop hand-off checks
// ----------------------------------------------
module dprp_regs_props (
   input wire logic                                   pclk,
   input wire logic                                   presetn,
   input wire logic                                   psel,
   input wire logic                                   penable,
   input wire logic                                   pwrite,
   input wire logic [15:0]                            paddr,
   input wire logic [31:0]                            prdata,
   input wire logic                                   pready,
   input wire logic                                   pslverr,
   input wire logic [2:0][1:0]                        active_ref,
   input wire logic [2:0]                             profile_live,
   input wire logic [2:0][7:0]                        chan_ctl,
   input wire dprp_pkg::dprp_profile_t [2:0]          applied_profile
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Setup decode; the checks look one edge ahead to the answer
   logic [13:0] idx;
   logic        setup;
   logic        trk0;
   assign idx   = paddr[15:2];
   assign setup = psel && !penable && (paddr[1:0] == 2'b00);
   assign trk0  = chan_ctl[0][0] && (active_ref[0] == dprp_pkg::REF_FOURTH);

   a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
      else $error("no answer after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_byte_wide_read: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data above one byte");
   a_top_reserved: assert property (
      setup && !pwrite && (idx == 14'h046A || idx == 14'h046D) |=> prdata[7:2] == 6'h0)
      else $error("reserved bits read back");
   a_ch1_mirror_ok: assert property (
      setup && idx >= 14'h0568 && idx <= 14'h0573 |=> pready && !pslverr)
      else $error("second channel copy refused");
   a_ch2_prof_err: assert property (
      setup && idx >= 14'h0668 && idx <= 14'h0673 |=> pready && pslverr)
      else $error("third channel profile accepted");
   a_ch2_ctl_ok: assert property (
      setup && (idx == 14'h0600 || idx == 14'h0630) |=> !pslverr)
      else $error("third channel control refused");
   a_live_track: assert property (trk0 |=> profile_live[0])
      else $error("tracking not reported");
   a_hold_untracked: assert property (!trk0 |=> $stable(applied_profile[0]))
      else $error("profile moved while not tracking");

   // Main scenarios reached
   c_prof_write: cover property (setup && pwrite && idx == 14'h0468);
   c_refused: cover property (pready && pslverr);
   c_live: cover property ($rose(profile_live[0]));
endmodule

bind dprp_regs dprp_regs_props i_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .active_ref(active_ref), .profile_live(profile_live), .chan_ctl(chan_ctl),
   .applied_profile(applied_profile)
);

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic                                 pclk;
   logic                                 presetn;
   logic                                 psel;
   logic                                 penable;
   logic                                 pwrite;
   logic [15:0]                          paddr;
   logic [31:0]                          pwdata;
   logic [2:0][1:0]                      active_ref;
   logic [31:0]                          prdata;
   logic                                 pready;
   logic                                 pslverr;
   dprp_pkg::dprp_profile_t [2:0]        applied_profile;
   logic [2:0]                           profile_live;
   logic [2:0][7:0]                      chan_ctl;
   logic [2:0][7:0]                      apll_cfg;
   int                                   errors = 0;
   int                                   compares = 0;

   localparam logic [13:0] B0  = dprp_pkg::IDX_BW_B0;
   localparam logic [13:0] CTL = dprp_pkg::IDX_CHAN_CTL;
   localparam logic [13:0] APL = dprp_pkg::IDX_APLL_CFG;
   localparam logic [13:0] CH1 = 14'h0100;
   localparam logic [13:0] CH2 = 14'h0200;
   localparam dprp_pkg::dprp_profile_t EXP = '{17'h1ABCD, 1'b1, 18'h23456, 24'h123456,
                                               24'h789ABC};
   // Byte image of EXP, low byte of each field first; about 10.9 kHz of
   // bandwidth, above the crystal floor and taken as far under a twentieth
   // of the detector rate, so the high margin set is chosen
   logic [7:0] pat [12] = '{8'hCD, 8'hAB, 8'h03, 8'h56, 8'h34, 8'h02,
                            8'h56, 8'h34, 8'h12, 8'hBC, 8'h9A, 8'h78};

   dprp_regs i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .active_ref(active_ref), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .applied_profile(applied_profile),
      .profile_live(profile_live), .chan_ctl(chan_ctl), .apll_cfg(apll_cfg)
   );

   // ----------------------------------------------
   // Clock, bus tasks and comparisons
   // ----------------------------------------------
   always #25 pclk = ~pclk;

   function automatic logic [15:0] ba(input logic [13:0] i);
      return {i, 2'b00};
   endfunction

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic chk_prof(input string nm, input dprp_pkg::dprp_profile_t x,
                           input dprp_pkg::dprp_profile_t g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask

   // Request is held until pready is seen at an edge; release is left to idle
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      if (pready !== 1'b1) begin
         errors++;
         stop_test();
      end
   endtask

   task automatic idle();
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", x, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------
   // Scenarios
   // ----------------------------------------------
   task automatic test_reset();
      for (int i = 0; i < 12; i++) begin
         rd_chk(ba(B0 + 14'(i)), 32'h0, 1'b0);
         rd_chk(ba(B0 + 14'(i) + CH1), 32'h0, 1'b0);
      end
      rd_chk(ba(CTL + CH2), 32'h0, 1'b0);
      rd_chk(ba(APL + CH2), 32'h0, 1'b0);
      chk("chan_ctl", 32'h0, {8'h0, chan_ctl});
      chk("apll_cfg", 32'h0, {8'h0, apll_cfg});
      chk("profile_live", 32'h0, {29'h0, profile_live});
      chk_prof("applied0", '0, applied_profile[0]);
      $display("test reset done");
   endtask

   // All ones written; only the documented bits of the top bytes stick
   task automatic test_fields();
      for (int i = 0; i < 12; i++) begin
         wr(ba(B0 + 14'(i)), 8'hFF);
      end
      for (int i = 0; i < 12; i++) begin
         rd_chk(ba(B0 + 14'(i)), (i == 2 || i == 5) ? 32'h03 : 32'hFF, 1'b0);
         rd_chk(ba(B0 + 14'(i) + CH1), 32'h0, 1'b0);
      end
      $display("test fields done");
   endtask

   task automatic test_apply();
      for (int i = 0; i < 12; i++) begin
         wr(ba(B0 + 14'(i)), pat[i]);
      end
      wr(ba(CTL), 8'h01);
      idle();
      active_ref[0] <= dprp_pkg::REF_FOURTH;
      repeat (3) @(posedge pclk);
      chk("profile_live0", 32'h1, {31'h0, profile_live[0]});
      chk("chan_ctl0", 32'h1, {24'h0, chan_ctl[0]});
      chk_prof("applied0", EXP, applied_profile[0]);
      // Bandwidth lowered to 122.9 Hz; its top byte write also returns the normal margin set
      wr(ba(B0 + 14'h1), 8'h04);
      wr(ba(B0 + 14'h2), 8'h00);
      idle();
      repeat (2) @(posedge pclk);
      chk("hpm_sel0", 32'h0, {31'h0, applied_profile[0].hpm_sel});
      chk("loop_bw0", 32'h004CD, {15'h0, applied_profile[0].loop_bw});
      active_ref[0] <= 2'h2;
      wr(ba(B0), 8'h11);
      idle();
      repeat (2) @(posedge pclk);
      chk("profile_live0", 32'h0, {31'h0, profile_live[0]});
      chk("loop_bw0", 32'h004CD, {15'h0, applied_profile[0].loop_bw});
      $display("test apply done");
   endtask

   // Copies are independent storage; third channel keeps only control and analog loop words
   task automatic test_mirror();
      for (int i = 0; i < 12; i++) begin
         wr(ba(B0 + 14'(i) + CH1), pat[i]);
      end
      wr(ba(CTL + CH1), 8'h01);
      wr(ba(CTL + CH2), 8'h5A);
      wr(ba(APL + CH2), 8'hA5);
      wr(ba(B0 + CH2), 8'h77);
      rd_chk(ba(B0 + CH2), 32'h0, 1'b1);
      rd_chk(ba(CTL + CH2), 32'h5A, 1'b0);
      rd_chk(ba(APL + CH2), 32'hA5, 1'b0);
      rd_chk(ba(14'h0467), 32'h0, 1'b1);
      rd_chk(ba(B0) + 16'h1, 32'h0, 1'b1);
      rd_chk(ba(B0), 32'h11, 1'b0);
      idle();
      active_ref[1] <= dprp_pkg::REF_FOURTH;
      repeat (3) @(posedge pclk);
      chk_prof("applied1", EXP, applied_profile[1]);
      chk("profile_live1", 32'h1, {31'h0, profile_live[1]});
      chk("chan_ctl1", 32'h1, {24'h0, chan_ctl[1]});
      chk("profile_live2", 32'h0, {31'h0, profile_live[2]});
      chk_prof("applied2", '0, applied_profile[2]);
      chk("chan_ctl2", 32'h5A, {24'h0, chan_ctl[2]});
      chk("apll_cfg2", 32'hA5, {24'h0, apll_cfg[2]});
      $display("test mirror done");
   endtask

   initial begin
      pclk       = 1'b0;
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 16'h0000;
      pwdata     = 32'h0000_0000;
      active_ref = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_reset();
      test_fields();
      test_apply();
      test_mirror();
      stop_test();
   end
endmodule
